// [hw/cfu_regs.svh]
// register offsets, field positions and reset values of the compare flag unit
//
// What this block does
// - skip compare entirely when execution condition off
// - double operand: next word high, named word low
// - double compare sets greater, equal or less
// - flags at relay bits 25505/6/7, all clear at reset; a clean non-table compare sets exactly one, a table compare writes only equal
// - sixteen pairs; bit clear on match, set otherwise
// - table compare: equal only when all pairs match
// - table compare errors when table overruns area
// - signed word compare uses two's complement
// - signed word: less below, greater above
// - signed double builds two signed 32-bit values
// - range: less below, equal inside, greater above
// - range errors when lower limit exceeds upper
// - pointer fault raises the error flag
// - flags hold until next flag-writing compare
`ifndef CFU_REGS_SVH
`define CFU_REGS_SVH

// apb byte offsets of the word registers
`define CFU_OFS_COMMAND 8'h00
`define CFU_OFS_FLAGS 8'h04
`define CFU_OFS_FIRST_LOW 8'h08
`define CFU_OFS_FIRST_HIGH 8'h0c
`define CFU_OFS_SECOND_LOW 8'h10
`define CFU_OFS_SECOND_HIGH 8'h14
`define CFU_OFS_COMPARE_VALUE 8'h18
`define CFU_OFS_LOWER_LIMIT 8'h1c
`define CFU_OFS_UPPER_LIMIT 8'h20
`define CFU_OFS_RESULT_WORD 8'h24
`define CFU_OFS_FIRST_TABLE_BASE 8'h28
`define CFU_OFS_SECOND_TABLE_BASE 8'h2c
`define CFU_OFS_AREA_LAST 8'h30

// table windows: paddr[7:6] selects the table, paddr[5:2] the entry
`define CFU_TABLE_FIRST_SEL 2'h1
`define CFU_TABLE_SECOND_SEL 2'h2

// command word fields
`define CFU_CMD_COND_BIT 0
`define CFU_CMD_OP_LSB 1
`define CFU_CMD_OP_MSB 3
`define CFU_CMD_PTR_FAULT_BIT 4

// flags word fields
`define CFU_FLAG_GREATER_BIT 0
`define CFU_FLAG_EQUAL_BIT 1
`define CFU_FLAG_LESS_BIT 2
`define CFU_FLAG_ERROR_BIT 3

// special-relay bit addresses the flags stand for
`define CFU_RELAY_GREATER_ADDR 25505
`define CFU_RELAY_EQUAL_ADDR 25506
`define CFU_RELAY_LESS_ADDR 25507

// reset values
`define CFU_RST_WORD 16'h0000
`define CFU_RST_AREA_LAST 16'hffff
`define CFU_RST_FLAGS 4'h0

`endif

// [hw/cfu_pkg.sv]
// types shared by the compare flag unit modules
package cfu_pkg;

    // compare operations selected by the command word
    typedef enum logic [2:0] {
        CFU_OP_DOUBLE_UNSIGNED,
        CFU_OP_TABLE_PAIR,
        CFU_OP_SIGNED_WORD,
        CFU_OP_SIGNED_DOUBLE,
        CFU_OP_RANGE,
        CFU_OP_RSVD5,
        CFU_OP_RSVD6,
        CFU_OP_RSVD7
    } cfu_op_e;

    // operand word as held in the data area
    typedef logic [15:0] cfu_word_t;

endpackage

// [hw/cfu_magnitude_cmp.sv]
// magnitude comparator with selectable signed or unsigned view
`timescale 1ns/100ps
module cfu_magnitude_cmp
    import cfu_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic [WIDTH-1:0] aValue,
    input wire logic [WIDTH-1:0] bValue,
    input wire logic signedMode,
    output logic aGreater,
    output logic aEqual,
    output logic aLess
);

    // flipping the sign bit maps two's complement order onto unsigned order
    logic [WIDTH-1:0] aBiased;
    logic [WIDTH-1:0] bBiased;

    // one comparator serves both views, saving a second carry chain
    always_comb begin
        aBiased = aValue;
        bBiased = bValue;
        aBiased[WIDTH-1] = aValue[WIDTH-1] ^ signedMode;
        bBiased[WIDTH-1] = bValue[WIDTH-1] ^ signedMode;
        aGreater = aBiased > bBiased;
        aEqual = aBiased == bBiased;
        aLess = aBiased < bBiased;
    end

endmodule

// [hw/cfu_table_match.sv]
// per-entry mismatch mask of two word tables
`timescale 1ns/100ps
module cfu_table_match
    import cfu_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int WORD_W = 16
) (
    input wire logic [DEPTH*WORD_W-1:0] firstTable,
    input wire logic [DEPTH*WORD_W-1:0] secondTable,
    output logic [DEPTH-1:0] mismatchMask,
    output logic allMatch
);

    // entry i of each table meets only entry i of the other
    for (genvar i = 0; i < DEPTH; i++) begin : gEntry
        assign mismatchMask[i] = firstTable[i*WORD_W +: WORD_W]
            != secondTable[i*WORD_W +: WORD_W];
    end

    // an all-zero mask is the same thing as every pair matching
    assign allMatch = ~|mismatchMask;

endmodule

// [hw/cfu_compare_flag_unit.sv]
// compare flag unit top: apb register file, compare datapath and flags
`timescale 1ns/100ps
`include "cfu_regs.svh"
module cfu_compare_flag_unit
    import cfu_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int TABLE_DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic greaterFlag,
    output logic equalFlag,
    output logic lessFlag,
    output logic errorFlag,
    output logic [TABLE_DEPTH-1:0] resultWord
);

    // ------------------------------------------------------------------
    // operand and configuration storage
    // ------------------------------------------------------------------
    cfu_word_t firstLow_reg; // named word of the first operand
    cfu_word_t firstHigh_reg; // next-address word of the first operand
    cfu_word_t secondLow_reg; // named word of the second operand
    cfu_word_t secondHigh_reg; // next-address word of the second operand
    cfu_word_t compareValue_reg; // data checked by the range compare
    cfu_word_t lowerLimit_reg; // inclusive lower bound
    cfu_word_t upperLimit_reg; // inclusive upper bound
    cfu_word_t firstTableBase_reg; // word address of first table start
    cfu_word_t secondTableBase_reg; // word address of second table start
    cfu_word_t areaLast_reg; // last word address of the data area
    cfu_word_t firstTable_reg [TABLE_DEPTH]; // first table entries
    cfu_word_t secondTable_reg [TABLE_DEPTH]; // second table entries
    logic [4:0] lastCommand_reg; // last command word, for read-back

    // flag and result state, each held between executed compares
    logic greater_reg;
    logic equal_reg;
    logic less_reg;
    logic error_reg;
    logic [TABLE_DEPTH-1:0] resultWord_reg;
    logic [31:0] readData_reg;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic accessPhase; // apb access phase, answered at once
    logic setupPhase; // apb setup phase, read data is fetched here
    logic writeStrobe; // write takes effect at this edge
    logic [7:0] byteAddr; // offset widened or cut to the map width
    logic [1:0] tableSel; // which table window is addressed
    logic [3:0] tableIndex; // entry index inside the window
    logic mapped; // offset lands on a register
    logic [31:0] readMux; // value that a read of paddr returns

    assign byteAddr = 8'(paddr);
    assign tableSel = byteAddr[7:6];
    assign tableIndex = byteAddr[5:2];
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign writeStrobe = accessPhase & pwrite & ~pslverr;

    // ready every access: read data was fetched during setup already
    assign pready = 1'b1;

    // unmapped offsets and misaligned words answer with an error
    assign pslverr = accessPhase & ~mapped;

    // ------------------------------------------------------------------
    // command decode and execution
    // ------------------------------------------------------------------
    logic commandWrite; // software issues a compare
    logic conditionOn; // execution condition of that compare
    logic pointerFault; // indirect pointer named a bad word
    cfu_op_e opCode; // which compare is asked for
    logic opKnown; // op code names an implemented compare
    logic execute; // the compare runs at this edge

    assign commandWrite = writeStrobe && byteAddr == `CFU_OFS_COMMAND;
    assign conditionOn = pwdata[`CFU_CMD_COND_BIT];
    assign pointerFault = pwdata[`CFU_CMD_PTR_FAULT_BIT];
    assign opCode = cfu_op_e'(pwdata[`CFU_CMD_OP_MSB:`CFU_CMD_OP_LSB]);
    assign opKnown = opCode inside {CFU_OP_DOUBLE_UNSIGNED, CFU_OP_TABLE_PAIR,
        CFU_OP_SIGNED_WORD, CFU_OP_SIGNED_DOUBLE, CFU_OP_RANGE};

    // an off condition skips everything, reserved codes likewise
    assign execute = commandWrite & conditionOn & opKnown;

    // ------------------------------------------------------------------
    // wide comparator for the word and double compares
    // ------------------------------------------------------------------
    logic [31:0] wideA;
    logic [31:0] wideB;
    logic wideSigned;
    logic wideGreater;
    logic wideEqual;
    logic wideLess;

    // operand shaping per compare kind
    always_comb begin
        wideA = {firstHigh_reg, firstLow_reg};
        wideB = {secondHigh_reg, secondLow_reg};
        wideSigned = 1'b0;
        case (opCode)
            CFU_OP_DOUBLE_UNSIGNED: begin
                wideSigned = 1'b0;
            end
            CFU_OP_SIGNED_DOUBLE: begin
                wideSigned = 1'b1;
            end
            CFU_OP_SIGNED_WORD: begin
                // sign extension keeps the 16-bit order intact
                wideA = {{16{firstLow_reg[15]}}, firstLow_reg};
                wideB = {{16{secondLow_reg[15]}}, secondLow_reg};
                wideSigned = 1'b1;
            end
            default: begin
                wideSigned = 1'b0;
            end
        endcase
    end

    cfu_magnitude_cmp #(
        .WIDTH(32)
    ) uWideCmp (
        .aValue(wideA),
        .bValue(wideB),
        .signedMode(wideSigned),
        .aGreater(wideGreater),
        .aEqual(wideEqual),
        .aLess(wideLess)
    );

    // ------------------------------------------------------------------
    // range compare: unsigned, limits inclusive
    // ------------------------------------------------------------------
    logic belowLower; // data under the lower limit
    logic aboveUpper; // data over the upper limit
    logic limitsCrossed; // lower limit above upper limit

    cfu_magnitude_cmp #(
        .WIDTH(16)
    ) uLowerCmp (
        .aValue(compareValue_reg),
        .bValue(lowerLimit_reg),
        .signedMode(1'b0),
        .aGreater(),
        .aEqual(),
        .aLess(belowLower)
    );

    cfu_magnitude_cmp #(
        .WIDTH(16)
    ) uUpperCmp (
        .aValue(compareValue_reg),
        .bValue(upperLimit_reg),
        .signedMode(1'b0),
        .aGreater(aboveUpper),
        .aEqual(),
        .aLess()
    );

    cfu_magnitude_cmp #(
        .WIDTH(16)
    ) uLimitCmp (
        .aValue(lowerLimit_reg),
        .bValue(upperLimit_reg),
        .signedMode(1'b0),
        .aGreater(limitsCrossed),
        .aEqual(),
        .aLess()
    );

    // ------------------------------------------------------------------
    // table pair compare and area overrun check
    // ------------------------------------------------------------------
    logic [TABLE_DEPTH*16-1:0] firstFlat;
    logic [TABLE_DEPTH*16-1:0] secondFlat;
    logic [TABLE_DEPTH-1:0] mismatchMask;
    logic allMatch;
    logic [16:0] firstTableEnd; // last word address of first table
    logic [16:0] secondTableEnd; // last word address of second table
    logic tableOverrun;

    // flatten the entry arrays for the match module
    always_comb begin
        firstFlat = '0;
        secondFlat = '0;
        for (int i = 0; i < TABLE_DEPTH; i++) begin
            firstFlat[i*16 +: 16] = firstTable_reg[i];
            secondFlat[i*16 +: 16] = secondTable_reg[i];
        end
    end

    cfu_table_match #(
        .DEPTH(TABLE_DEPTH),
        .WORD_W(16)
    ) uTableMatch (
        .firstTable(firstFlat),
        .secondTable(secondFlat),
        .mismatchMask(mismatchMask),
        .allMatch(allMatch)
    );

    // 17-bit sums so a base near the top cannot wrap past the check
    assign firstTableEnd = {1'b0, firstTableBase_reg} + 17'(TABLE_DEPTH - 1);
    assign secondTableEnd = {1'b0, secondTableBase_reg} + 17'(TABLE_DEPTH - 1);
    assign tableOverrun = firstTableEnd > {1'b0, areaLast_reg}
        || secondTableEnd > {1'b0, areaLast_reg};

    // error case of the compare being issued
    logic execError;
    always_comb begin
        execError = pointerFault;
        case (opCode)
            CFU_OP_TABLE_PAIR: begin
                execError = pointerFault | tableOverrun;
            end
            CFU_OP_RANGE: begin
                execError = pointerFault | limitsCrossed;
            end
            default: begin
                execError = pointerFault;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // flag update: only an executed compare touches the flags
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            greater_reg <= 1'b0;
            equal_reg <= 1'b0;
            less_reg <= 1'b0;
        end else if (execute && !execError) begin
            case (opCode)
                CFU_OP_TABLE_PAIR: begin
                    // greater and less have no meaning here and keep their value
                    equal_reg <= allMatch;
                end
                CFU_OP_RANGE: begin
                    less_reg <= belowLower;
                    greater_reg <= aboveUpper;
                    equal_reg <= ~belowLower & ~aboveUpper;
                end
                default: begin
                    greater_reg <= wideGreater;
                    equal_reg <= wideEqual;
                    less_reg <= wideLess;
                end
            endcase
        end
    end

    // error flag reflects the most recently executed compare only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            error_reg <= 1'b0;
        end else if (execute) begin
            error_reg <= execError;
        end
    end

    // result word is written only by a clean table compare
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resultWord_reg <= '0;
        end else if (execute && !execError && opCode == CFU_OP_TABLE_PAIR) begin
            resultWord_reg <= mismatchMask;
        end
    end

    // ------------------------------------------------------------------
    // software-written registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            firstLow_reg <= `CFU_RST_WORD;
            firstHigh_reg <= `CFU_RST_WORD;
            secondLow_reg <= `CFU_RST_WORD;
            secondHigh_reg <= `CFU_RST_WORD;
            compareValue_reg <= `CFU_RST_WORD;
            lowerLimit_reg <= `CFU_RST_WORD;
            upperLimit_reg <= `CFU_RST_WORD;
            firstTableBase_reg <= `CFU_RST_WORD;
            secondTableBase_reg <= `CFU_RST_WORD;
            areaLast_reg <= `CFU_RST_AREA_LAST;
            lastCommand_reg <= '0;
        end else if (writeStrobe) begin
            // operand words keep only the low half of the bus word
            case (byteAddr)
                `CFU_OFS_COMMAND: lastCommand_reg <= pwdata[4:0];
                `CFU_OFS_FIRST_LOW: firstLow_reg <= pwdata[15:0];
                `CFU_OFS_FIRST_HIGH: firstHigh_reg <= pwdata[15:0];
                `CFU_OFS_SECOND_LOW: secondLow_reg <= pwdata[15:0];
                `CFU_OFS_SECOND_HIGH: secondHigh_reg <= pwdata[15:0];
                `CFU_OFS_COMPARE_VALUE: compareValue_reg <= pwdata[15:0];
                `CFU_OFS_LOWER_LIMIT: lowerLimit_reg <= pwdata[15:0];
                `CFU_OFS_UPPER_LIMIT: upperLimit_reg <= pwdata[15:0];
                `CFU_OFS_FIRST_TABLE_BASE: firstTableBase_reg <= pwdata[15:0];
                `CFU_OFS_SECOND_TABLE_BASE: secondTableBase_reg <= pwdata[15:0];
                `CFU_OFS_AREA_LAST: areaLast_reg <= pwdata[15:0];
                default: begin
                    // flags and result are read-only; writes there are dropped
                end
            endcase
        end
    end

    // table entries, written through their two windows
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                firstTable_reg[i] <= `CFU_RST_WORD;
                secondTable_reg[i] <= `CFU_RST_WORD;
            end
        end else if (writeStrobe) begin
            if (tableSel == `CFU_TABLE_FIRST_SEL) begin
                firstTable_reg[tableIndex] <= pwdata[15:0];
            end else if (tableSel == `CFU_TABLE_SECOND_SEL) begin
                secondTable_reg[tableIndex] <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // read side
    // ------------------------------------------------------------------
    always_comb begin
        readMux = '0;
        mapped = 1'b1;
        if (tableSel == `CFU_TABLE_FIRST_SEL && byteAddr[1:0] == 2'h0) begin
            readMux = {16'h0000, firstTable_reg[tableIndex]};
        end else if (tableSel == `CFU_TABLE_SECOND_SEL && byteAddr[1:0] == 2'h0) begin
            readMux = {16'h0000, secondTable_reg[tableIndex]};
        end else begin
            case (byteAddr)
                `CFU_OFS_COMMAND: readMux = {27'h0000000, lastCommand_reg};
                `CFU_OFS_FLAGS: begin
                    readMux[`CFU_FLAG_GREATER_BIT] = greater_reg;
                    readMux[`CFU_FLAG_EQUAL_BIT] = equal_reg;
                    readMux[`CFU_FLAG_LESS_BIT] = less_reg;
                    readMux[`CFU_FLAG_ERROR_BIT] = error_reg;
                end
                `CFU_OFS_FIRST_LOW: readMux = {16'h0000, firstLow_reg};
                `CFU_OFS_FIRST_HIGH: readMux = {16'h0000, firstHigh_reg};
                `CFU_OFS_SECOND_LOW: readMux = {16'h0000, secondLow_reg};
                `CFU_OFS_SECOND_HIGH: readMux = {16'h0000, secondHigh_reg};
                `CFU_OFS_COMPARE_VALUE: readMux = {16'h0000, compareValue_reg};
                `CFU_OFS_LOWER_LIMIT: readMux = {16'h0000, lowerLimit_reg};
                `CFU_OFS_UPPER_LIMIT: readMux = {16'h0000, upperLimit_reg};
                `CFU_OFS_RESULT_WORD: readMux = 32'(resultWord_reg);
                `CFU_OFS_FIRST_TABLE_BASE: readMux = {16'h0000, firstTableBase_reg};
                `CFU_OFS_SECOND_TABLE_BASE: readMux = {16'h0000, secondTableBase_reg};
                `CFU_OFS_AREA_LAST: readMux = {16'h0000, areaLast_reg};
                default: begin
                    // unmapped: zero data and an error answer
                    mapped = 1'b0;
                end
            endcase
        end
    end

    // read data is captured in setup so prdata comes from a flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readData_reg <= '0;
        end else if (setupPhase && !pwrite) begin
            readData_reg <= readMux;
        end
    end

    assign prdata = readData_reg;
    assign greaterFlag = greater_reg;
    assign equalFlag = equal_reg;
    assign lessFlag = less_reg;
    assign errorFlag = error_reg;
    assign resultWord = resultWord_reg;

endmodule

// [tb/cfu_checker.sv]
// port-level assertions for the compare flag unit
`timescale 1ns/100ps
module cfu_checker
    import cfu_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int TABLE_DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic greaterFlag,
    input wire logic equalFlag,
    input wire logic lessFlag,
    input wire logic errorFlag,
    input wire logic [TABLE_DEPTH-1:0] resultWord
);
    logic acc; // completed write access
    logic exec; // command write that runs a compare
    logic [31:0] aVal; // shadow of the first double operand
    logic [31:0] bVal; // shadow of the second double operand
    logic [3:0] fl; // flags in register order
    assign acc = psel && penable && pwrite && pready;
    assign exec = acc && paddr == 'h00 && pwdata[0] && pwdata[3:1] <= 3'h4;
    assign fl = {errorFlag, lessFlag, equalFlag, greaterFlag};
    // shadows let results be judged without seeing inside the register file
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aVal <= 32'h0;
            bVal <= 32'h0;
        end else if (acc) begin
            case (paddr)
                'h08: aVal[15:0] <= pwdata[15:0];
                'h0c: aVal[31:16] <= pwdata[15:0];
                'h10: bVal[15:0] <= pwdata[15:0];
                'h14: bVal[31:16] <= pwdata[15:0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_cond_off_skip: assert property (acc && paddr == 'h00 && !pwdata[0] |=>
        $stable(fl) && $stable(resultWord)) else $error("skipped compare changed flags");
    a_flags_hold: assert property (!exec |=> $stable(fl) && $stable(resultWord))
        else $error("flags moved without a compare");
    a_fault_error: assert property (exec && pwdata[4] |=> errorFlag
        && $stable(fl[2:0])) else $error("pointer fault not flagged");
    a_one_flag: assert property (exec && pwdata[3:1] != 3'h1 |=>
        errorFlag || $onehot(fl[2:0])) else $error("not exactly one result flag");
    a_double_unsigned: assert property (exec && !pwdata[4] && pwdata[3:1] == 3'h0 |=>
        fl == {1'b0, aVal < bVal, aVal == bVal, aVal > bVal}) else $error("double compare");
    a_signed_double: assert property (exec && !pwdata[4] && pwdata[3:1] == 3'h3 |=>
        fl == {1'b0, $signed(aVal) < $signed(bVal), aVal == bVal, $signed(aVal) > $signed(bVal)})
        else $error("signed double compare");
    a_signed_word: assert property (exec && !pwdata[4] && pwdata[3:1] == 3'h2 |=>
        fl == {1'b0, $signed(aVal[15:0]) < $signed(bVal[15:0]), aVal[15:0] == bVal[15:0],
        $signed(aVal[15:0]) > $signed(bVal[15:0])}) else $error("signed word compare");
    a_table_equal: assert property (exec && !pwdata[4] && pwdata[3:1] == 3'h1 |=>
        errorFlag || equalFlag == (resultWord == '0)) else $error("table equal flag");
    c_table: cover property (exec && pwdata[3:1] == 3'h1);
    c_range: cover property (exec && pwdata[3:1] == 3'h4);
    c_fault: cover property (exec && pwdata[4]);
endmodule
bind cfu_compare_flag_unit cfu_checker #(.ADDR_W(ADDR_W), .TABLE_DEPTH(TABLE_DEPTH)) u_chk (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .greaterFlag(greaterFlag), .equalFlag(equalFlag), .lessFlag(lessFlag),
    .errorFlag(errorFlag), .resultWord(resultWord));

// [tb/cfu_testbench.sv]
// self-checking bench for the compare flag unit
`timescale 1ns/100ps
`include "cfu_regs.svh"
module testbench;
    import cfu_pkg::*;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdata;
    logic greaterFlag, equalFlag, lessFlag, errorFlag;
    logic [15:0] resultWord;
    logic [3:0] fl; // flags in register order
    int fails = 0, n_tests = 0, cycles = 0;
    assign fl = {errorFlag, lessFlag, equalFlag, greaterFlag};
    cfu_compare_flag_unit DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .greaterFlag(greaterFlag), .equalFlag(equalFlag),
        .lessFlag(lessFlag), .errorFlag(errorFlag), .resultWord(resultWord));
    always #2 mclk = ~mclk;
    // hang guard: about a hundred transfers need far fewer cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // one apb transfer plus an idle cycle, so no signal is driven twice per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // wait for pready however long it takes; only the bench timeout ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic cmd(input cfu_op_e op, input logic cond, input logic fault);
        apb(1'b1, `CFU_OFS_COMMAND, {27'h0, fault, op, cond});
    endtask
    task automatic do_cmp(input cfu_op_e op, input logic [31:0] a, b, input logic [3:0] ex);
        apb(1'b1, 8'h08, {16'h0, a[15:0]});
        apb(1'b1, 8'h0c, {16'h0, a[31:16]});
        apb(1'b1, 8'h10, {16'h0, b[15:0]});
        apb(1'b1, 8'h14, {16'h0, b[31:16]});
        cmd(op, 1'b1, 1'b0);
        check({12'h0, fl}, {12'h0, ex}, "compare flags");
    endtask
    task automatic do_range(input logic [15:0] cv, ll, ul, input logic [3:0] ex);
        apb(1'b1, 8'h18, {16'h0, cv});
        apb(1'b1, 8'h1c, {16'h0, ll});
        apb(1'b1, 8'h20, {16'h0, ul});
        cmd(CFU_OP_RANGE, 1'b1, 1'b0);
        check({12'h0, fl}, {12'h0, ex}, "range flags");
    endtask
    // sixteen pairs with mismatches at chosen entries, then area overrun
    task automatic t_table;
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h40 + 8'(4 * i), {16'h0, 16'(i * 257)});
            apb(1'b1, 8'h80 + 8'(4 * i), (i == 3 || i == 15) ? 32'hdead : 32'(i * 257));
        end
        apb(1'b1, 8'h30, 32'h00ff);
        apb(1'b1, 8'h28, 32'h0010);
        apb(1'b1, 8'h2c, 32'h00f0);
        cmd(CFU_OP_TABLE_PAIR, 1'b1, 1'b0);
        check(resultWord, 16'h8008, "mismatch mask");
        check({15'h0, equalFlag}, 16'h0, "equal on mismatch");
        apb(1'b1, 8'h8c, 32'h0303);
        apb(1'b1, 8'hbc, 32'h0f0f);
        cmd(CFU_OP_TABLE_PAIR, 1'b1, 1'b0);
        check({fl[3], fl[1], resultWord[13:0]}, 16'h4000, "all match");
        apb(1'b1, 8'h2c, 32'h00f1);
        apb(1'b1, 8'hbc, 32'h0);
        cmd(CFU_OP_TABLE_PAIR, 1'b1, 1'b0);
        check({fl[3], resultWord[14:0]}, 16'h8000, "table overrun");
    endtask
    // skipped and reserved commands leave the results alone; a faulted one sets only the error flag
    task automatic t_skip;
        do_cmp(CFU_OP_DOUBLE_UNSIGNED, 32'h5, 32'h7, 4'h4);
        apb(1'b1, 8'h08, 32'h9);
        cmd(CFU_OP_DOUBLE_UNSIGNED, 1'b0, 1'b0);
        check({12'h0, fl}, 16'h4, "condition off");
        cmd(CFU_OP_RSVD5, 1'b1, 1'b0);
        check({12'h0, fl}, 16'h4, "reserved op");
        cmd(CFU_OP_DOUBLE_UNSIGNED, 1'b1, 1'b1);
        check({12'h0, fl}, 16'hc, "pointer fault");
        apb(1'b0, `CFU_OFS_FLAGS, 32'h0);
        check(rdata[15:0], 16'hc, "flags readback");
        apb(1'b0, 8'h34, 32'h0);
        check({15'h0, rerr}, 16'h1, "unmapped error");
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check({fl, resultWord[11:0]}, 16'h0, "reset values");
        do_cmp(CFU_OP_DOUBLE_UNSIGNED, 32'h80000000, 32'h00000001, 4'h1);
        do_cmp(CFU_OP_DOUBLE_UNSIGNED, 32'h0000ffff, 32'h00010000, 4'h4);
        do_cmp(CFU_OP_DOUBLE_UNSIGNED, 32'h12345678, 32'h12345678, 4'h2);
        do_cmp(CFU_OP_SIGNED_DOUBLE, 32'h82b6057b, 32'h056a99db, 4'h4);
        do_cmp(CFU_OP_SIGNED_DOUBLE, 32'h00000001, 32'hffffffff, 4'h1);
        do_cmp(CFU_OP_SIGNED_WORD, 32'h00008000, 32'h00000001, 4'h4);
        do_cmp(CFU_OP_SIGNED_WORD, 32'h00000005, 32'h0000fffb, 4'h1);
        do_cmp(CFU_OP_SIGNED_WORD, 32'h12340007, 32'h00000007, 4'h2);
        do_range(16'h000f, 16'h0010, 16'hab1f, 4'h4);
        do_range(16'h0010, 16'h0010, 16'hab1f, 4'h2);
        do_range(16'hab1f, 16'h0010, 16'hab1f, 4'h2);
        do_range(16'hab20, 16'h0010, 16'hab1f, 4'h1);
        do_range(16'h6fa4, 16'h0020, 16'h0010, 4'h9);
        t_skip();
        t_table();
        test_done();
    end
endmodule
